// ### inc/smcp_pkg.sv
// Operation
// - Two independent ports, 300 to 57600 bps.
// - Fixed frame: eight data, no parity, one stop.
// - Ports start at 1200 bps.
// - Terminal-mode rate mismatch returns port to 1200.
// - Run of carriage returns forces 1200 bps.
// - Rate change takes effect at once.
// - Point-to-point port has terminal-ready and carrier-detect.
// - Both ports always active, no strap.
// - Balanced port starts in packet mode.
// - Consecutive carriage returns select terminal mode.
// - Start-of-text character selects packet mode.
// - Shared bus uses packet mode only; here three CRs in a row or a config write also put it in terminal mode.
// - Read both latches and the fault.
// - Five override outputs act like panel buttons.
// - Controller boots itself at power-on.
// - All five buttons together reboot the controller.
// - Alarm relay de-energized means alarm.
// - Transmit and receive relay drives never overlap.
// - Commands act only after terminating carriage return.
// - Rate command takes eight rates, on its port.
package smcp_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int DIV_W = 20;

  localparam logic [2:0] RATE_300 = 3'h0;
  localparam logic [2:0] RATE_1200 = 3'h1;
  localparam logic [2:0] RATE_2400 = 3'h2;
  localparam logic [2:0] RATE_4800 = 3'h3;
  localparam logic [2:0] RATE_9600 = 3'h4;
  localparam logic [2:0] RATE_19200 = 3'h5;
  localparam logic [2:0] RATE_38400 = 3'h6;
  localparam logic [2:0] RATE_57600 = 3'h7;
  localparam logic [2:0] RATE_DEFAULT = RATE_1200;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_P0_CFG = 8'h08;
  localparam logic [7:0] REG_P1_CFG = 8'h0C;
  localparam logic [7:0] REG_P0_DATA = 8'h10;
  localparam logic [7:0] REG_P1_DATA = 8'h14;

  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_MODE_BIT = 3;
  localparam int CFG_DTR_BIT = 4;
  localparam int CFG_RXV_BIT = 8;
  localparam int CFG_BUSY_BIT = 9;
  localparam int CFG_LINE_BIT = 10;
  localparam int CFG_DCD_BIT = 11;
  localparam int CTRL_ALARM_BIT = 5;

  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_STX = 8'h02;
  localparam logic [3:0] CR_TERM_COUNT = 4'h3;
  localparam logic [3:0] CR_FALLBACK_COUNT = 4'h5;
  localparam logic [3:0] FE_LIMIT = 4'h2;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] DATA_BITS = 4'h8;

  localparam int BUTTON_HOLD_US = 50_000;
  localparam int OVERRIDE_PULSE_US = 100;
  localparam int RELAY_PULSE_US = 30_000;
  localparam int RELAY_GAP_US = 20_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  typedef enum logic {MODE_PACKET, MODE_TERMINAL} smcp_mode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} smcp_rx_t;
  typedef enum logic [1:0] {RLY_IDLE, RLY_TX, RLY_RX, RLY_GAP} smcp_rly_t;
endpackage

// ### hdl/smcp_core.sv
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
module smcp_core
  import smcp_pkg::*;
#(
  parameter int BUTTON_HOLD_CYC = BUTTON_HOLD_US * CYC_PER_US,
  parameter int OVERRIDE_CYC = OVERRIDE_PULSE_US * CYC_PER_US,
  parameter int RELAY_PULSE_CYC = RELAY_PULSE_US * CYC_PER_US,
  parameter int RELAY_GAP_CYC = RELAY_GAP_US * CYC_PER_US
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Balanced port
  input wire logic i_p0_rxd,
  output logic o_p0_txd,
  output logic o_p0_tx_en,
  // Point-to-point port
  input wire logic i_p1_rxd,
  input wire logic i_p1_dcd,
  output logic o_p1_txd,
  output logic o_p1_dtr,
  // Switch logic
  input wire logic i_tx_latch,
  input wire logic i_rx_latch,
  input wire logic i_switch_fault,
  input wire logic [4:0] i_button,
  input wire logic i_tx_relay_req,
  input wire logic i_rx_relay_req,
  output logic o_force_tx_side_a,
  output logic o_force_rx_side_a,
  output logic o_force_tx_side_b,
  output logic o_force_rx_side_b,
  output logic o_force_auto,
  output logic o_tx_relay_drive,
  output logic o_rx_relay_drive,
  output logic o_alarm_relay_energize,
  output logic o_reboot,
  output logic o_ready
);

  if (BUTTON_HOLD_CYC < 1 || OVERRIDE_CYC < 1 || RELAY_PULSE_CYC < 1 || RELAY_GAP_CYC < 1)
  begin : g_bad_param
    $error("smcp_core: every timing count must be at least one cycle");
  end

  function automatic logic [DIV_W-1:0] rate_div(input logic [2:0] code);
    int baud;
    baud = 1200;
    case (code)
      RATE_300: baud = 300;
      RATE_1200: baud = 1200;
      RATE_2400: baud = 2400;
      RATE_4800: baud = 4800;
      RATE_9600: baud = 9600;
      RATE_19200: baud = 19200;
      RATE_38400: baud = 38400;
      default: baud = 57600;
    endcase
    return DIV_W'(CLK_HZ / baud);
  endfunction

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    return (v == 4'hF) ? v : v + 4'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [8:0] meta_reg;
  logic [8:0] sync_reg;
  logic [4:0] btn_sync;
  logic [1:0] rxd_sync;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_reg <= 9'h003;
      sync_reg <= 9'h003;
    end
    else
    begin
      meta_reg <= {i_switch_fault, i_rx_latch, i_tx_latch, i_p1_dcd,
                   i_rx_relay_req, i_tx_relay_req, 1'b0, i_p1_rxd, i_p0_rxd};
      sync_reg <= meta_reg;
    end
  end

  logic [4:0] btn_meta;
  logic [4:0] btn_reg;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      btn_meta <= 5'h00;
      btn_reg <= 5'h00;
    end
    else
    begin
      btn_meta <= i_button;
      btn_reg <= btn_meta;
    end
  end
  assign btn_sync = btn_reg;
  assign rxd_sync = sync_reg[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Boot and button reboot.

  logic [31:0] hold_cnt;
  logic soft_rst;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ready <= 1'b0;
      hold_cnt <= 32'h0;
      o_reboot <= 1'b0;
    end
    else
    begin
      o_ready <= 1'b1;
      o_reboot <= 1'b0;
      if (&btn_sync)
      begin
        if (hold_cnt == 32'(BUTTON_HOLD_CYC - 1))
          o_reboot <= 1'b1;
        if (hold_cnt != 32'(BUTTON_HOLD_CYC))
          hold_cnt <= hold_cnt + 32'h1;
      end
      else
        hold_cnt <= 32'h0;
    end
  end
  assign soft_rst = o_reboot;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, registered read data.

  logic acc;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_word;
  logic [1:0] wr_data_port;
  logic [1:0] wr_cfg_port;
  logic [1:0] rd_data_port;
  logic wr_ctrl;

  assign acc = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign wr_ctrl = wr_pend_reg && wr_addr_reg == REG_CTRL;
  assign wr_cfg_port = {wr_pend_reg && wr_addr_reg == REG_P1_CFG,
                        wr_pend_reg && wr_addr_reg == REG_P0_CFG};
  assign wr_data_port = {wr_pend_reg && wr_addr_reg == REG_P1_DATA,
                         wr_pend_reg && wr_addr_reg == REG_P0_DATA};
  assign rd_data_port = {acc && !i_hwrite && i_haddr[7:0] == REG_P1_DATA,
                         acc && !i_hwrite && i_haddr[7:0] == REG_P0_DATA};

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      o_hrdata <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= acc && i_hwrite;
      wr_addr_reg <= i_haddr[7:0];
      if (acc && !i_hwrite)
        o_hrdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial ports: both always running, fixed 8N1 frame.

  logic [2:0] rate_reg [2];
  smcp_mode_t mode_reg [2];
  smcp_rx_t rx_state [2];
  logic [DIV_W-1:0] rx_cnt [2];
  logic [3:0] rx_bits [2];
  logic [7:0] rx_shift [2];
  logic [7:0] rx_data_reg [2];
  logic [1:0] rx_valid_reg;
  logic [1:0] line_done_reg;
  logic [3:0] cr_cnt [2];
  logic [3:0] fe_cnt [2];
  logic [9:0] tx_shift [2];
  logic [3:0] tx_bits [2];
  logic [DIV_W-1:0] tx_cnt [2];
  logic [1:0] txd_reg;
  logic dtr_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        rate_reg[p] <= RATE_DEFAULT;
        mode_reg[p] <= (p == 0) ? MODE_PACKET : MODE_TERMINAL;
        rx_state[p] <= RX_IDLE;
        rx_cnt[p] <= '0;
        rx_bits[p] <= 4'h0;
        rx_shift[p] <= 8'h00;
        rx_data_reg[p] <= 8'h00;
        cr_cnt[p] <= 4'h0;
        fe_cnt[p] <= 4'h0;
      end
      rx_valid_reg <= 2'b00;
      line_done_reg <= 2'b00;
      dtr_reg <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (rd_data_port[p])
        begin
          rx_valid_reg[p] <= 1'b0;
          line_done_reg[p] <= 1'b0;
        end
        if (rx_cnt[p] != '0)
          rx_cnt[p] <= rx_cnt[p] - DIV_W'(1);
        case (rx_state[p])
          RX_IDLE:
            if (!rxd_sync[p])
            begin
              rx_state[p] <= RX_START;
              rx_cnt[p] <= rate_div(rate_reg[p]) >> 1;
            end
          RX_START:
            if (rx_cnt[p] == '0)
            begin
              rx_state[p] <= rxd_sync[p] ? RX_IDLE : RX_DATA;
              rx_cnt[p] <= rate_div(rate_reg[p]) - DIV_W'(1);
              rx_bits[p] <= 4'h0;
            end
          RX_DATA:
            if (rx_cnt[p] == '0)
            begin
              rx_shift[p] <= {rxd_sync[p], rx_shift[p][7:1]};
              rx_bits[p] <= rx_bits[p] + 4'h1;
              rx_cnt[p] <= rate_div(rate_reg[p]) - DIV_W'(1);
              if (rx_bits[p] == DATA_BITS - 4'h1)
                rx_state[p] <= RX_STOP;
            end
          RX_STOP:
            if (rx_cnt[p] == '0)
            begin
              rx_state[p] <= RX_IDLE;
              if (rxd_sync[p])
              begin
                rx_data_reg[p] <= rx_shift[p];
                rx_valid_reg[p] <= 1'b1;
                fe_cnt[p] <= 4'h0;
                if (rx_shift[p] == CHAR_STX)
                begin
                  mode_reg[p] <= MODE_PACKET;
                  cr_cnt[p] <= 4'h0;
                end
                else if (rx_shift[p] == CHAR_CR)
                begin
                  line_done_reg[p] <= 1'b1;
                  cr_cnt[p] <= sat_inc(cr_cnt[p]);
                  if (sat_inc(cr_cnt[p]) >= CR_TERM_COUNT)
                    mode_reg[p] <= MODE_TERMINAL;
                  if (sat_inc(cr_cnt[p]) >= CR_FALLBACK_COUNT)
                    rate_reg[p] <= RATE_DEFAULT;
                end
                else
                  cr_cnt[p] <= 4'h0;
              end
              else if (mode_reg[p] == MODE_TERMINAL)
              begin
                // A CR sent at a slower rate arrives as a broken frame here.
                fe_cnt[p] <= sat_inc(fe_cnt[p]);
                if (sat_inc(fe_cnt[p]) >= FE_LIMIT)
                begin
                  rate_reg[p] <= RATE_DEFAULT;
                  fe_cnt[p] <= 4'h0;
                end
              end
            end
          default: rx_state[p] <= RX_IDLE;
        endcase
        // Software writes land after the receiver so a new command wins.
        if (wr_cfg_port[p])
        begin
          rate_reg[p] <= i_hwdata[CFG_RATE_LSB +: 3];
          mode_reg[p] <= i_hwdata[CFG_MODE_BIT] ? MODE_TERMINAL : MODE_PACKET;
          cr_cnt[p] <= 4'h0;
          fe_cnt[p] <= 4'h0;
        end
        if (soft_rst)
        begin
          rate_reg[p] <= RATE_DEFAULT;
          mode_reg[p] <= (p == 0) ? MODE_PACKET : MODE_TERMINAL;
        end
      end
      if (wr_cfg_port[1])
        dtr_reg <= i_hwdata[CFG_DTR_BIT];
      if (soft_rst)
        dtr_reg <= 1'b0;
    end
  end

  // Writes to a busy transmitter are dropped; software polls the busy bit.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        tx_shift[p] <= 10'h3FF;
        tx_bits[p] <= 4'h0;
        tx_cnt[p] <= '0;
      end
      txd_reg <= 2'b11;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (tx_bits[p] == 4'h0)
        begin
          txd_reg[p] <= 1'b1;
          if (wr_data_port[p])
          begin
            tx_shift[p] <= {1'b1, i_hwdata[7:0], 1'b0};
            tx_bits[p] <= FRAME_BITS;
            tx_cnt[p] <= rate_div(rate_reg[p]) - DIV_W'(1);
            txd_reg[p] <= 1'b0;
          end
        end
        else if (tx_cnt[p] == '0)
        begin
          tx_bits[p] <= tx_bits[p] - 4'h1;
          tx_shift[p] <= {1'b1, tx_shift[p][9:1]};
          tx_cnt[p] <= rate_div(rate_reg[p]) - DIV_W'(1);
          txd_reg[p] <= (tx_bits[p] == 4'h1) ? 1'b1 : tx_shift[p][1];
        end
        else
          tx_cnt[p] <= tx_cnt[p] - DIV_W'(1);
      end
    end
  end

  assign o_p0_txd = txd_reg[0];
  assign o_p1_txd = txd_reg[1];
  assign o_p0_tx_en = tx_bits[0] != 4'h0;
  assign o_p1_dtr = dtr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Override pulses, parallel to the panel buttons.

  logic [4:0] force_reg;
  logic [31:0] force_cnt;
  logic sw_alarm_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      force_reg <= 5'h00;
      force_cnt <= 32'h0;
      sw_alarm_reg <= 1'b0;
    end
    else
    begin
      if (force_cnt != 32'h0)
        force_cnt <= force_cnt - 32'h1;
      else
        force_reg <= 5'h00;
      if (wr_ctrl)
      begin
        sw_alarm_reg <= i_hwdata[CTRL_ALARM_BIT];
        if (i_hwdata[4:0] != 5'h00)
        begin
          // Held as long as a button press so the switch logic sees it alike.
          force_reg <= i_hwdata[4:0];
          force_cnt <= 32'(OVERRIDE_CYC - 1);
        end
      end
      if (soft_rst)
      begin
        force_reg <= 5'h00;
        force_cnt <= 32'h0;
      end
    end
  end

  assign o_force_tx_side_a = force_reg[0];
  assign o_force_rx_side_a = force_reg[1];
  assign o_force_tx_side_b = force_reg[2];
  assign o_force_rx_side_b = force_reg[3];
  assign o_force_auto = force_reg[4];

  ////////////////////////////////////////////////////////////////////////////
  // Relay actuation spacing and alarm relay.

  smcp_rly_t rly_state;
  logic [31:0] rly_cnt;
  logic tx_pend_reg;
  logic rx_pend_reg;
  logic [1:0] req_last_reg;
  logic [1:0] req_rise;
  logic alarm_drive_reg;

  assign req_rise = sync_reg[4:3] & ~req_last_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rly_state <= RLY_IDLE;
      rly_cnt <= 32'h0;
      tx_pend_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      req_last_reg <= 2'b00;
    end
    else
    begin
      req_last_reg <= sync_reg[4:3];
      if (rly_cnt != 32'h0)
        rly_cnt <= rly_cnt - 32'h1;
      case (rly_state)
        RLY_IDLE:
          if (tx_pend_reg || req_rise[0])
          begin
            rly_state <= RLY_TX;
            rly_cnt <= 32'(RELAY_PULSE_CYC - 1);
          end
          else if (rx_pend_reg || req_rise[1])
          begin
            rly_state <= RLY_RX;
            rly_cnt <= 32'(RELAY_PULSE_CYC - 1);
          end
        RLY_TX, RLY_RX:
          if (rly_cnt == 32'h0)
          begin
            rly_state <= RLY_GAP;
            rly_cnt <= 32'(RELAY_GAP_CYC - 1);
          end
        RLY_GAP:
          if (rly_cnt == 32'h0)
            rly_state <= RLY_IDLE;
        default: rly_state <= RLY_IDLE;
      endcase
      // A request that rises while the other relay works waits its turn.
      if (rly_state == RLY_IDLE && !tx_pend_reg && !req_rise[0])
        rx_pend_reg <= 1'b0;
      else if (req_rise[1])
        rx_pend_reg <= 1'b1;
      if (rly_state == RLY_IDLE)
        tx_pend_reg <= 1'b0;
      else if (req_rise[0])
        tx_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      alarm_drive_reg <= 1'b0;
    else
      alarm_drive_reg <= o_ready && !sync_reg[8] && !sw_alarm_reg;
  end

  assign o_tx_relay_drive = rly_state == RLY_TX;
  assign o_rx_relay_drive = rly_state == RLY_RX;
  assign o_alarm_relay_energize = alarm_drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.

  function automatic logic [31:0] cfg_word(input int p);
    logic [31:0] w;
    w = 32'h0;
    w[CFG_RATE_LSB +: 3] = rate_reg[p];
    w[CFG_MODE_BIT] = mode_reg[p] == MODE_TERMINAL;
    w[CFG_RXV_BIT] = rx_valid_reg[p];
    w[CFG_BUSY_BIT] = tx_bits[p] != 4'h0;
    w[CFG_LINE_BIT] = line_done_reg[p];
    return w;
  endfunction

  always_comb
  begin
    rd_word = 32'h0;
    if (i_haddr[7:0] == REG_CTRL)
      rd_word = {26'h0, sw_alarm_reg, force_reg};
    else if (i_haddr[7:0] == REG_STATUS)
      rd_word = {28'h0, alarm_drive_reg, sync_reg[8:6]};
    else if (i_haddr[7:0] == REG_P0_CFG)
      rd_word = cfg_word(0);
    else if (i_haddr[7:0] == REG_P1_CFG)
    begin
      rd_word = cfg_word(1);
      rd_word[CFG_DTR_BIT] = dtr_reg;
      rd_word[CFG_DCD_BIT] = sync_reg[5];
    end
    else if (i_haddr[7:0] == REG_P0_DATA)
      rd_word = {24'h0, rx_data_reg[0]};
    else if (i_haddr[7:0] == REG_P1_DATA)
      rd_word = {24'h0, rx_data_reg[1]};
  end

endmodule

// ### tb/smcp_chk.sv
`timescale 1ns/10ps
module smcp_chk
  import smcp_pkg::*;
#(
  parameter int BUTTON_HOLD_CYC = 20,
  parameter int OVERRIDE_CYC = 4,
  parameter int RELAY_PULSE_CYC = 10,
  parameter int RELAY_GAP_CYC = 5
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Watched inputs
  input wire logic i_switch_fault,
  input wire logic [4:0] i_button,
  // Watched outputs
  input wire logic o_p0_txd,
  input wire logic o_p0_tx_en,
  input wire logic o_force_tx_side_a,
  input wire logic o_force_rx_side_a,
  input wire logic o_force_tx_side_b,
  input wire logic o_force_rx_side_b,
  input wire logic o_force_auto,
  input wire logic o_tx_relay_drive,
  input wire logic o_rx_relay_drive,
  input wire logic o_alarm_relay_energize,
  input wire logic o_reboot,
  input wire logic o_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic f_any;
  logic d_any;
  logic [15:0] f_cnt;
  logic [15:0] r_cnt;
  logic [15:0] g_cnt;
  logic [15:0] b_cnt;
  assign f_any = |{o_force_tx_side_a, o_force_rx_side_a, o_force_tx_side_b,
    o_force_rx_side_b, o_force_auto};
  assign d_any = o_tx_relay_drive | o_rx_relay_drive;
  ////////////////////////////////////////////////////////////////////////////
  // Gap counter starts saturated so the first actuation after reset is legal.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
    if (!i_resetn)
    begin
      f_cnt <= 16'h0;
      r_cnt <= 16'h0;
      g_cnt <= 16'hFFFF;
      b_cnt <= 16'h0;
    end
    else
    begin
      f_cnt <= f_any ? f_cnt + 16'h1 : 16'h0;
      r_cnt <= d_any ? r_cnt + 16'h1 : 16'h0;
      g_cnt <= d_any ? 16'h0 : ((g_cnt == 16'hFFFF) ? g_cnt : g_cnt + 16'h1);
      b_cnt <= (i_button == 5'h1F) ? b_cnt + 16'h1 : 16'h0;
    end
  ////////////////////////////////////////////////////////////////////////////
  sequence hold_done_s;
    (i_button == 5'h1F) && (b_cnt == 16'(BUTTON_HOLD_CYC));
  endsequence
  sequence tx_start_s;
    $rose(o_p0_tx_en) ##0 !o_p0_txd;
  endsequence
  relay_excl_a: assert property (!(o_tx_relay_drive && o_rx_relay_drive))
    else $error("relay drives overlap");
  relay_width_a: assert property ($fell(d_any) |-> r_cnt == 16'(RELAY_PULSE_CYC))
    else $error("relay pulse length wrong");
  relay_gap_a: assert property ($rose(d_any) |-> g_cnt >= 16'(RELAY_GAP_CYC))
    else $error("relay actuations too close");
  force_width_a: assert property ($fell(f_any) |-> f_cnt == 16'(OVERRIDE_CYC))
    else $error("override pulse length wrong");
  alarm_fault_a: assert property (i_switch_fault [*5] |-> !o_alarm_relay_energize)
    else $error("alarm relay energized during fault");
  boot_ready_a: assert property ($rose(i_resetn) |=> o_ready)
    else $error("not ready after reset release");
  tx_start_a: assert property ($rose(o_p0_tx_en) |-> tx_start_s)
    else $error("frame does not open with start bit");
  tx_idle_a: assert property (!o_p0_tx_en |-> o_p0_txd)
    else $error("transmit line not idle high");
  reboot_when_a: assert property (hold_done_s |-> ##[0:8] o_reboot)
    else $error("reboot missing after all buttons held");
  reboot_cause_a: assert property (o_reboot |-> b_cnt >= 16'(BUTTON_HOLD_CYC))
    else $error("reboot without button hold");
endmodule

bind smcp_core smcp_chk #(.BUTTON_HOLD_CYC(BUTTON_HOLD_CYC), .OVERRIDE_CYC(OVERRIDE_CYC),
  .RELAY_PULSE_CYC(RELAY_PULSE_CYC), .RELAY_GAP_CYC(RELAY_GAP_CYC)) u_chk (.i_clk_sys,
  .i_resetn, .i_switch_fault, .i_button, .o_p0_txd, .o_p0_tx_en, .o_force_tx_side_a,
  .o_force_rx_side_a, .o_force_tx_side_b, .o_force_rx_side_b, .o_force_auto,
  .o_tx_relay_drive, .o_rx_relay_drive, .o_alarm_relay_energize, .o_reboot, .o_ready);

// ### tb/smcp_host.sv
`timescale 1ns/10ps
module smcp_host
(
  // Clock
  input wire logic i_clk_sys,
  // Serial lines
  input wire logic i_txd,
  output logic o_rxd
);
  int div = 2170;
  logic [7:0] rxq[$];
  logic [7:0] sh;
  // The host holds a mark level between frames, as a real line driver does.
  initial o_rxd = 1'b1;
  task automatic tick;
    repeat (div) @(posedge i_clk_sys);
  endtask
  task automatic send(input logic [7:0] v, input logic stop);
    o_rxd <= 1'b0;
    tick();
    for (int i = 0; i < 8; i++)
    begin
      o_rxd <= v[i];
      tick();
    end
    o_rxd <= stop;
    tick();
    o_rxd <= 1'b1;
    tick();
  endtask
  always
  begin
    @(negedge i_txd);
    repeat (div / 2) @(posedge i_clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      tick();
      sh[i] = i_txd;
    end
    tick();
    if (i_txd)
      rxq.push_back(sh);
  end
endmodule

// ### tb/tb_serial_mc_port_control.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_serial_mc_port_control
  import smcp_pkg::*;
;
  logic i_clk_sys, i_resetn, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic i_p0_rxd, o_p0_txd, o_p0_tx_en, i_p1_rxd, i_p1_dcd, o_p1_txd, o_p1_dtr;
  logic i_tx_latch, i_rx_latch, i_switch_fault, i_tx_relay_req, i_rx_relay_req;
  logic [4:0] i_button;
  logic o_force_tx_side_a, o_force_rx_side_a, o_force_tx_side_b, o_force_rx_side_b;
  logic o_force_auto, o_tx_relay_drive, o_rx_relay_drive, o_alarm_relay_energize;
  logic o_reboot, o_ready;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  int bad_count, n_compared, cyc, seed, t_cnt, r_cnt, rb_cnt;
  assign i_hready = o_hreadyout;
  smcp_core #(.BUTTON_HOLD_CYC(20), .OVERRIDE_CYC(4), .RELAY_PULSE_CYC(10),
    .RELAY_GAP_CYC(5)) DUT (.i_clk_sys, .i_resetn, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_p0_rxd, .o_p0_txd, .o_p0_tx_en, .i_p1_rxd, .i_p1_dcd, .o_p1_txd, .o_p1_dtr,
    .i_tx_latch, .i_rx_latch, .i_switch_fault, .i_button, .i_tx_relay_req,
    .i_rx_relay_req, .o_force_tx_side_a, .o_force_rx_side_a, .o_force_tx_side_b,
    .o_force_rx_side_b, .o_force_auto, .o_tx_relay_drive, .o_rx_relay_drive,
    .o_alarm_relay_energize, .o_reboot, .o_ready);
  smcp_host u_h0 (.i_clk_sys, .i_txd(o_p0_txd), .o_rxd(i_p0_rxd));
  smcp_host u_h1 (.i_clk_sys, .i_txd(o_p1_txd), .o_rxd(i_p1_rxd));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // The ceiling leaves room for four frames at the top rate plus setup.
  always @(posedge i_clk_sys)
  begin
    cyc++;
    t_cnt += o_tx_relay_drive;
    r_cnt += o_rx_relay_drive;
    rb_cnt += o_reboot;
    if (cyc == 99000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_haddr <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    rd = o_hrdata;
  endtask
  task automatic cfg_chk(input logic [7:0] a, input logic [3:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd[3:0], e)
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hf141;
    {i_resetn, i_hwrite, i_htrans, i_haddr, i_hwdata} = '0;
    {i_p1_dcd, i_tx_latch, i_rx_latch, i_switch_fault, i_button} = '0;
    {i_tx_relay_req, i_rx_relay_req} = '0;
    i_hsel = 1'b1;
    i_hsize = 3'h2;
    repeat (12) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    cfg_chk(REG_P0_CFG, {MODE_PACKET, RATE_DEFAULT});
    cfg_chk(REG_P1_CFG, {MODE_TERMINAL, RATE_DEFAULT});
    @(posedge i_clk_sys);
    {i_tx_latch, i_rx_latch, i_p1_dcd} <= 3'($random(seed));
    repeat (4) @(posedge i_clk_sys);
    ahb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[3:0], {2'h2, i_rx_latch, i_tx_latch})
    ahb(1'b0, REG_P1_CFG, 32'h0);
    `CHK(rd[11], i_p1_dcd)
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(o_hresp, 1'b0)
    done("defaults");
    for (int i = 0; i < 8; i++)
    begin
      ahb(1'b1, REG_P0_CFG, i);
      cfg_chk(REG_P0_CFG, 4'(i));
    end
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b1, REG_CTRL, 32'h1 << i);
      #1;
      `CHK({o_force_auto, o_force_rx_side_b, o_force_tx_side_b, o_force_rx_side_a,
        o_force_tx_side_a}, 5'(1 << i))
      repeat (6) @(posedge i_clk_sys);
    end
    done("rates_overrides");
    ahb(1'b1, REG_CTRL, 32'h20);
    ahb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[3], 1'b0)
    `CHK(o_alarm_relay_energize, 1'b0)
    ahb(1'b1, REG_CTRL, 32'h0);
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_alarm_relay_energize, 1'b1)
    i_switch_fault <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    `CHK(o_alarm_relay_energize, 1'b0)
    i_switch_fault <= 1'b0;
    {i_tx_relay_req, i_rx_relay_req} <= 2'h3;
    repeat (3) @(posedge i_clk_sys);
    {i_tx_relay_req, i_rx_relay_req} <= 2'h0;
    repeat (60) @(posedge i_clk_sys);
    `CHK(t_cnt, 10)
    `CHK(r_cnt, 10)
    done("alarm_relays");
    ahb(1'b1, REG_P0_CFG, 32'hF);
    ahb(1'b1, REG_P1_CFG, 32'h1F);
    #1;
    `CHK(o_p1_dtr, 1'b1)
    u_h0.div = CLK_HZ / 57600;
    u_h1.div = CLK_HZ / 57600;
    b = 8'($random(seed));
    exp_q.push_back(b);
    exp_q.push_back(~b);
    fork
      u_h0.send(CHAR_STX, 1'b1);
      u_h1.send(8'h41, 1'b1);
      begin
        ahb(1'b1, REG_P0_DATA, {24'h0, b});
        ahb(1'b1, REG_P1_DATA, {24'h0, ~b});
      end
    join
    repeat (100) @(posedge i_clk_sys);
    `CHK(u_h0.rxq.size(), 1)
    `CHK(u_h0.rxq[0], exp_q[0])
    `CHK(u_h1.rxq[0], exp_q[1])
    ahb(1'b0, REG_P0_CFG, 32'h0);
    `CHK(rd[3], MODE_PACKET)
    ahb(1'b0, REG_P1_DATA, 32'h0);
    `CHK(rd[7:0], 8'h41)
    cfg_chk(REG_P0_CFG, {MODE_PACKET, RATE_57600});
    fork
      repeat (2) u_h1.send(8'h55, 1'b0);
      repeat (3) u_h0.send(CHAR_CR, 1'b1);
    join
    cfg_chk(REG_P1_CFG, {MODE_TERMINAL, RATE_DEFAULT});
    cfg_chk(REG_P0_CFG, {MODE_TERMINAL, RATE_57600});
    `CHK(rd[10], 1'b1)
    done("serial");
    i_button <= 5'h1F;
    repeat (30) @(posedge i_clk_sys);
    i_button <= 5'h0;
    repeat (5) @(posedge i_clk_sys);
    `CHK(rb_cnt, 1)
    cfg_chk(REG_P0_CFG, {MODE_PACKET, RATE_DEFAULT});
    done("reboot");
    end_of_test();
  end
endmodule
